// ===== rtl/lfs_pkg.sv
package lfs_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 9;
    localparam int CODE_W = 8;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 4;
    // Command frame: write flag, address, odd parity, data.
    localparam int F_WR = 15;
    localparam int F_ADDR_HI = 14;
    localparam int F_ADDR_LO = 10;
    localparam int F_DATA_HI = 8;
    localparam logic [ADDR_W-1:0] ADDR_FAULT = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_OT_LIMIT = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_CH1_PEAK = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_CH2_PEAK = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_CH1_OFF = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_TEMP = 5'h09;
    localparam int B_COMM = 0;
    localparam int B_OT = 1;
    localparam int B_GSL1 = 2;
    localparam int B_GSL2 = 3;
    localparam int B_RESTART = 4;
    localparam logic [DATA_W-1:0] FAULT_RST = 9'h010;
    localparam logic [CODE_W-1:0] CODE_RST = 8'h80;
    localparam int MV_PER_VOLT = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int DAC_UPDATE_NS = 1000;
    localparam int DAC_UPDATE_CYC = DAC_UPDATE_NS / CLK_PERIOD_NS;
endpackage

// ===== rtl/lfs_serial_port.sv
`timescale 1ns/1ps
module lfs_serial_port #(
    parameter int FRAME_BITS = 16
) (
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  sclk_i,
    input  wire logic                  chip_sel_n_i,
    input  wire logic                  mosi_i,
    input  wire logic [FRAME_BITS-1:0] resp_word_i,
    output logic                       miso_o,
    output logic                       miso_oe_n_o,
    output logic                       frame_start_o,
    output logic                       word_valid_o,
    output logic                       count_bad_o,
    output logic [FRAME_BITS-1:0]      word_o
);
    logic                      sclk_q_r;
    logic                      csn_q_r;
    logic                      any_r;
    logic [lfs_pkg::CNT_W-1:0] cnt_r;
    logic [FRAME_BITS-1:0]     tx_r;
    logic                      rise;
    logic                      fall;
    logic                      csn_rise;

    assign rise = sclk_i & ~sclk_q_r & ~chip_sel_n_i;
    assign fall = ~sclk_i & sclk_q_r & ~chip_sel_n_i;
    assign csn_rise = chip_sel_n_i & ~csn_q_r;
    assign frame_start_o = ~chip_sel_n_i & csn_q_r;
    // Only the last full word of a transfer is executed.
    assign word_valid_o = csn_rise & any_r & (cnt_r == '0);
    assign count_bad_o = csn_rise & (cnt_r != '0);
    assign miso_o = tx_r[FRAME_BITS-1];
    assign miso_oe_n_o = chip_sel_n_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q_r <= 1'b0;
            csn_q_r <= 1'b1;
        end else begin
            sclk_q_r <= sclk_i;
            csn_q_r <= chip_sel_n_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
            any_r <= 1'b0;
            word_o <= '0;
        end else if (frame_start_o) begin
            cnt_r <= '0;
            any_r <= 1'b0;
        end else if (rise) begin
            cnt_r <= cnt_r + 1'b1;
            any_r <= 1'b1;
            word_o <= {word_o[FRAME_BITS-2:0], mosi_i};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_r <= '0;
        end else if (frame_start_o) begin
            tx_r <= resp_word_i;
        end else if (fall) begin
            tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
        end
    end
endmodule

// ===== rtl/lfs_regs.sv
`timescale 1ns/1ps
module lfs_regs #(
    parameter int NCH = 2
) (
    input  wire logic                         clk_i,
    input  wire logic                         resetn_i,
    input  wire logic                         sclk_i,
    input  wire logic                         chip_sel_n_i,
    input  wire logic                         mosi_i,
    output logic                              miso_o,
    output logic                              miso_oe_n_o,
    input  wire logic [NCH-1:0]               boot_low_i,
    input  wire logic [lfs_pkg::CODE_W-1:0]   die_temp_sample_i,
    output logic [NCH-1:0]                    gate_off_o,
    output logic [NCH-1:0][lfs_pkg::CODE_W-1:0] peak_current_code_o,
    output logic [lfs_pkg::CODE_W-1:0]        off_time_code_o,
    output logic [lfs_pkg::CODE_W-1:0]        overtemp_limit_code_o
);
    localparam int FB = lfs_pkg::FRAME_BITS;
    localparam int AW = lfs_pkg::ADDR_W;
    localparam int DW = lfs_pkg::DATA_W;
    localparam int CW = lfs_pkg::CODE_W;

    logic          frame_start;
    logic          word_valid;
    logic          count_bad;
    logic [FB-1:0] word;
    logic [FB-1:0] resp_word;

    logic          wr_cmd;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic          par_ok;
    logic          data_ok;
    logic          good;
    logic          serial_err;
    logic          rd_ok;
    logic          wr_ok;
    logic          flag_rd_clr;
    logic          ot_cond;

    logic          comm_flag_r;
    logic          ot_flag_r;
    logic          restart_r;
    logic [NCH-1:0] gsl_r;
    logic [NCH-1:0] gate_off_r;
    logic [NCH-1:0][CW-1:0] peak_r;
    logic [CW-1:0] limit_r;
    logic [CW-1:0] off_r;
    logic [DW-1:0] fault_bits;
    logic [DW-1:0] rd_mux;
    logic [DW-1:0] rd_data_r;
    logic          last_wr_r;
    logic [AW-1:0] last_addr_r;
    logic [DW-1:0] last_wdata_r;

    lfs_serial_port #(
        .FRAME_BITS (FB)
    ) u_port (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .sclk_i        (sclk_i),
        .chip_sel_n_i  (chip_sel_n_i),
        .mosi_i        (mosi_i),
        .resp_word_i   (resp_word),
        .miso_o        (miso_o),
        .miso_oe_n_o   (miso_oe_n_o),
        .frame_start_o (frame_start),
        .word_valid_o  (word_valid),
        .count_bad_o   (count_bad),
        .word_o        (word)
    );

    assign wr_cmd = word[lfs_pkg::F_WR];
    assign addr = word[lfs_pkg::F_ADDR_HI:lfs_pkg::F_ADDR_LO];
    assign data = word[lfs_pkg::F_DATA_HI:0];
    // Odd parity over the whole frame, parity bit included.
    assign par_ok = ^word;
    assign data_ok = wr_cmd | (data == '0);
    assign good = word_valid & par_ok & data_ok;
    assign serial_err = count_bad | (word_valid & ~(par_ok & data_ok));
    assign rd_ok = good & ~wr_cmd;
    assign wr_ok = good & wr_cmd;
    // A faulty read must not destroy flags the host never saw.
    assign flag_rd_clr = rd_ok & (addr == lfs_pkg::ADDR_FAULT);
    assign ot_cond = die_temp_sample_i > limit_r;

    always_comb begin
        fault_bits = '0;
        fault_bits[lfs_pkg::B_COMM] = comm_flag_r;
        fault_bits[lfs_pkg::B_OT] = ot_flag_r;
        fault_bits[lfs_pkg::B_GSL1] = gsl_r[0];
        fault_bits[lfs_pkg::B_GSL2] = gsl_r[1];
        fault_bits[lfs_pkg::B_RESTART] = restart_r;
    end

    // Set wins over the read clear, so an error in the clearing cycle survives.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            comm_flag_r <= lfs_pkg::FAULT_RST[lfs_pkg::B_COMM];
        end else begin
            comm_flag_r <= serial_err | (comm_flag_r & ~flag_rd_clr);
        end
    end

    // The asynchronous reset stands for the power-on reset of the device.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            restart_r <= lfs_pkg::FAULT_RST[lfs_pkg::B_RESTART];
        end else if (flag_rd_clr) begin
            restart_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ot_flag_r <= lfs_pkg::FAULT_RST[lfs_pkg::B_OT];
        end else begin
            ot_flag_r <= ot_cond | (ot_flag_r & ~flag_rd_clr);
        end
    end

    genvar g;
    for (g = 0; g < NCH; g++) begin : g_ch
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                gate_off_r[g] <= 1'b0;
                gsl_r[g] <= 1'b0;
            end else begin
                gate_off_r[g] <= boot_low_i[g];
                gsl_r[g] <= boot_low_i[g] | (gsl_r[g] & ~flag_rd_clr);
            end
        end

        // The code goes to the converter as is: one count per millivolt.
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                peak_r[g] <= lfs_pkg::CODE_RST;
            end else if (wr_ok && addr == AW'(lfs_pkg::ADDR_CH1_PEAK + g)) begin
                peak_r[g] <= data[CW-1:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            limit_r <= lfs_pkg::CODE_RST;
        end else if (wr_ok && addr == lfs_pkg::ADDR_OT_LIMIT) begin
            limit_r <= data[CW-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            off_r <= lfs_pkg::CODE_RST;
        end else if (wr_ok && addr == lfs_pkg::ADDR_CH1_OFF) begin
            off_r <= data[CW-1:0];
        end
    end

    assign gate_off_o = gate_off_r;
    assign peak_current_code_o = peak_r;
    assign off_time_code_o = off_r;
    assign overtemp_limit_code_o = limit_r;

    // Unmapped addresses and reserved bit 8 read as zero.
    always_comb begin
        rd_mux = '0;
        case (addr)
            lfs_pkg::ADDR_FAULT:    rd_mux = fault_bits;
            lfs_pkg::ADDR_OT_LIMIT: rd_mux = {1'b0, limit_r};
            lfs_pkg::ADDR_CH1_PEAK: rd_mux = {1'b0, peak_r[0]};
            lfs_pkg::ADDR_CH2_PEAK: rd_mux = {1'b0, peak_r[1]};
            lfs_pkg::ADDR_CH1_OFF:  rd_mux = {1'b0, off_r};
            lfs_pkg::ADDR_TEMP:     rd_mux = {1'b0, die_temp_sample_i};
            default:                rd_mux = '0;
        endcase
    end

    // Read data is taken before the clear lands, so the host sees what was set.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_r <= '0;
        end else if (rd_ok) begin
            rd_data_r <= rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_wr_r <= 1'b0;
            last_addr_r <= '0;
            last_wdata_r <= '0;
        end else if (good) begin
            last_wr_r <= wr_cmd;
            last_addr_r <= addr;
            last_wdata_r <= data;
        end
    end

    // Bit 15 is always the live comm fault; read answers add the live flags.
    always_comb begin
        if (last_wr_r) begin
            resp_word = {comm_flag_r, last_addr_r, 1'b0, last_wdata_r};
        end else begin
            resp_word = {comm_flag_r, restart_r, gsl_r[1], gsl_r[0], ot_flag_r,
                         2'b00, rd_data_r};
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_comm_count_err:
        assert property (count_bad |=> comm_flag_r)
        else $error("bit count error did not set comm fault");

    a_comm_read_data:
        assert property (word_valid && !wr_cmd && data != '0 |=> comm_flag_r)
        else $error("nonzero read data did not set comm fault");

    a_comm_parity:
        assert property (word_valid && !par_ok |=> comm_flag_r)
        else $error("parity error did not set comm fault");

    a_comm_clear:
        assert property (flag_rd_clr && !count_bad |=> !comm_flag_r)
        else $error("clean fault read did not clear comm fault");

    a_restart_clear:
        assert property (flag_rd_clr |=> !restart_r ##1 !restart_r)
        else $error("supply restart flag not cleared by read");

    a_no_dirty_clear:
        assert property (word_valid && !par_ok && restart_r |=> restart_r)
        else $error("faulty read cleared a flag");

    a_gate_off_ch1:
        assert property (boot_low_i[0] |=> gate_off_o[0] && gsl_r[0])
        else $error("bootstrap low did not turn channel off");

    a_gate_flag_hold:
        assert property (flag_rd_clr && boot_low_i[1] |=> gsl_r[1])
        else $error("gate supply flag cleared while condition present");

    a_overtemp_set:
        assert property (die_temp_sample_i > limit_r |=> ot_flag_r)
        else $error("overtemp flag not set above limit");

    a_peak_update:
        assert property (wr_ok && addr == lfs_pkg::ADDR_CH1_PEAK
                         |=> peak_current_code_o[0] == $past(word[CW-1:0]))
        else $error("peak setpoint not applied in time");

    a_limit_read:
        assert property (rd_ok && addr == lfs_pkg::ADDR_OT_LIMIT
                         |=> rd_data_r == {1'b0, $past(limit_r)})
        else $error("limit read back wrong");

    a_resp_fault:
        assert property (frame_start |=> miso_o == $past(comm_flag_r))
        else $error("response did not lead with comm fault");

    a_comm_set:
        assert property (serial_err |=> comm_flag_r)
        else $error("serial error did not set comm fault");

    a_comm_hold:
        assert property (comm_flag_r && !flag_rd_clr |=> comm_flag_r)
        else $error("comm fault dropped without a clean read");

    a_comm_quiet:
        assert property (!comm_flag_r && !serial_err |=> !comm_flag_r)
        else $error("comm fault set without a serial error");

    a_restart_hold:
        assert property (restart_r && !flag_rd_clr |=> restart_r)
        else $error("supply restart flag dropped without a read");

    a_restart_no_set:
        assert property (!restart_r |=> !restart_r)
        else $error("supply restart flag set without power up");

    a_gate_off_ch2:
        assert property (boot_low_i[1] |=> gate_off_o[1] && gsl_r[1])
        else $error("bootstrap low did not turn channel 2 off");

    a_gate_on_ch1:
        assert property (!boot_low_i[0] |=> !gate_off_o[0])
        else $error("channel 1 held off with bootstrap supply good");

    a_gsl_hold:
        assert property (flag_rd_clr && boot_low_i[0] |=> gsl_r[0])
        else $error("channel 1 gate flag cleared while condition present");

    a_gsl_clear:
        assert property (flag_rd_clr && !boot_low_i[0] |=> !gsl_r[0])
        else $error("channel 1 gate flag not cleared by read");

    a_gsl_keep:
        assert property (gsl_r[1] && !flag_rd_clr |=> gsl_r[1])
        else $error("channel 2 gate flag dropped without a read");

    a_ot_hold:
        assert property (flag_rd_clr && ot_cond |=> ot_flag_r)
        else $error("overtemp flag cleared while condition present");

    a_ot_clear:
        assert property (flag_rd_clr && !ot_cond |=> !ot_flag_r)
        else $error("overtemp flag not cleared by read");

    a_ot_quiet:
        assert property (!ot_flag_r && !ot_cond |=> !ot_flag_r)
        else $error("overtemp flag set at or below limit");

    a_peak2_update:
        assert property (wr_ok && addr == lfs_pkg::ADDR_CH2_PEAK
                         |=> peak_current_code_o[1] == $past(data[CW-1:0]))
        else $error("channel 2 peak setpoint not applied in time");

    a_limit_update:
        assert property (wr_ok && addr == lfs_pkg::ADDR_OT_LIMIT
                         |=> overtemp_limit_code_o == $past(data[CW-1:0]))
        else $error("overtemp limit write not applied");

    a_off_update:
        assert property (wr_ok && addr == lfs_pkg::ADDR_CH1_OFF
                         |=> off_time_code_o == $past(data[CW-1:0]))
        else $error("off time write not applied");

    a_code_stable:
        assert property (!wr_ok |=> $stable(peak_current_code_o) && $stable(off_time_code_o)
                         && $stable(overtemp_limit_code_o))
        else $error("setpoint changed without a good write");

    a_fault_read:
        assert property (rd_ok && addr == lfs_pkg::ADDR_FAULT |=> rd_data_r == $past(fault_bits))
        else $error("fault flags read back wrong");

    a_read_keeps:
        assert property (!rd_ok |=> $stable(rd_data_r))
        else $error("read data changed without a good read");

    a_temp_read:
        assert property (rd_ok && addr == lfs_pkg::ADDR_TEMP
                         |=> rd_data_r == {1'b0, $past(die_temp_sample_i)})
        else $error("temperature sample read back wrong");
endmodule

// ===== sim/lfs_host.sv
`timescale 1ns/1ps
// The serial clock idles low. The data line toggles once each time the device is deselected.
module lfs_host (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      chip_sel_n_o,
    output logic      mosi_o
);
    initial begin
        sclk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Each serial phase lasts two clk cycles, the shortest the device samples safely.
    task automatic xfer(input int nb, input logic [15:0] w, output logic [15:0] r);
        r = '0;
        chip_sel_n_o = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi_o = w[15 - (i % 16)];
            repeat (2) @(negedge clk_i);
            if (i < 16) r = {r[14:0], miso_i};
            sclk_o = 1'b1;
            repeat (2) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (2) @(negedge clk_i);
        chip_sel_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

// ===== sim/lfs_regs_test.sv
`timescale 1ns/1ps
module lfs_regs_test;
    logic            clk_i;
    logic            resetn_i;
    logic            sclk;
    logic            csn;
    logic            mosi;
    logic            miso;
    logic [1:0]      boot_low;
    logic [1:0]      gate_off;
    logic [1:0][7:0] peak;
    logic [7:0]      temp;
    logic [7:0]      off_code;
    logic [7:0]      lim_code;
    logic [31:0]     seed = 32'h28458b05;
    int              n_mismatch = 0;
    int              tests_run = 0;
    int              flt;
    int              lim;
    int              pk1;
    int              pk2;
    int              off;
    int              rd;
    int              a;
    int              d;
    bit              last_wr;
    logic            miso_oe_n;
    logic [15:0]     last_w;

    lfs_regs #(.NCH(2)) i_lfs_regs (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
        .chip_sel_n_i(csn), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
        .boot_low_i(boot_low), .die_temp_sample_i(temp), .gate_off_o(gate_off),
        .peak_current_code_o(peak), .off_time_code_o(off_code),
        .overtemp_limit_code_o(lim_code));
    lfs_host i_lfs_host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .chip_sel_n_o(csn),
        .mosi_o(mosi));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // The device may drive its data line only while it is selected.
    always @(posedge clk_i) begin
        check(16'(miso_oe_n), 16'(csn), "data line enable");
    end

    // Set always wins over a clear, so this runs after every clear as well.
    function automatic void refresh();
        if (temp > lim) flt |= 2;
        if (boot_low[0]) flt |= 4;
        if (boot_low[1]) flt |= 8;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic do_reset();
        resetn_i = 1'b0;
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        flt = 'h10;
        lim = 'h80;
        pk1 = 'h80;
        pk2 = 'h80;
        off = 'h80;
        rd = 0;
        last_wr = 0;
        refresh();
        check({lim_code, off_code}, 16'h8080, "limit and off time");
        check(peak, 16'h8080, "peak codes");
    endtask

    task automatic set_in(input logic [1:0] b, input logic [7:0] t);
        boot_low = b;
        temp = t;
        repeat (3) @(negedge clk_i);
        refresh();
        check(16'(gate_off), 16'(b), "gate off");
    endtask

    // The model moves on only for frames the device may execute, as the design does.
    task automatic cmd(input bit wr, input int ad, input int dt, input int nb = 16,
                       input bit badp = 0);
        logic [15:0] w;
        logic [15:0] r;
        logic [15:0] e;
        bit          good;
        w = {wr, ad[4:0], 1'b0, dt[8:0]};
        w[9] = (~^w) ^ badp;
        e = last_wr ? {flt[0], last_w[14:10], 1'b0, last_w[8:0]}
                    : {flt[0], flt[4], flt[3], flt[2], flt[1], 2'b00, rd[8:0]};
        i_lfs_host.xfer(nb, w, r);
        if (nb >= 16) check(r, e, "response");
        good = nb > 0 && nb % 16 == 0 && !badp && (wr || dt == 0);
        if (!good) begin
            flt |= 1;
        end else if (wr) begin
            last_wr = 1;
            last_w = w;
            case (ad)
                2: lim = dt & 'hff;
                3: pk1 = dt & 'hff;
                4: pk2 = dt & 'hff;
                5: off = dt & 'hff;
                default: ;
            endcase
        end else begin
            last_wr = 0;
            case (ad)
                1: rd = flt;
                2: rd = lim;
                3: rd = pk1;
                4: rd = pk2;
                5: rd = off;
                9: rd = temp;
                default: rd = 0;
            endcase
            if (ad == 1) flt = 0;
        end
        refresh();
        check({lim_code, off_code}, {lim[7:0], off[7:0]}, "limit and off time");
        check(peak, {pk2[7:0], pk1[7:0]}, "peak codes");
    endtask

    initial begin
        #5000000;
        n_mismatch++;
        $display("[FAIL] %0t run took too long", $time);
        end_of_test();
    end

    initial begin
        boot_low = 2'b00;
        temp = 8'h00;
        do_reset();
        cmd(0, 1, 0);
        cmd(0, 1, 0);
        cmd(0, 2, 0);
        cmd(1, 4, 'h1a5);
        cmd(0, 4, 0);
        cmd(1, 1, 'h1ff);
        cmd(0, 1, 0);
        $display("test reset values done");
        repeat (14) begin
            a = int'(rnd() & 32'h1f);
            d = int'(rnd() & 32'h1ff);
            cmd(1, a, d);
            cmd(0, a, 0);
        end
        $display("test random access done");
        for (int k = 0; k < 4; k++) begin
            cmd(k != 1, 3, (k == 1) ? 5 : 'h11 * (k + 1), (k == 2) ? 15 : (k == 3) ? 17 : 16,
                k == 0);
            cmd(0, 1, 0, 16, 1);
            cmd(0, 1, 0);
            cmd(0, 3, 0);
        end
        cmd(1, 3, 'h44, 32);
        cmd(0, 3, 0);
        $display("test serial errors done");
        set_in(2'b01, 8'h81);
        cmd(0, 1, 0);
        cmd(0, 1, 0);
        set_in(2'b10, 8'h80);
        cmd(0, 1, 0);
        cmd(1, 2, 'h7f);
        cmd(0, 1, 0);
        set_in(2'b00, 8'h00);
        cmd(0, 1, 0);
        cmd(0, 1, 0);
        $display("test fault flags done");
        do_reset();
        cmd(0, 5, 0);
        cmd(0, 1, 0, 16, 1);
        cmd(0, 1, 0);
        cmd(0, 9, 0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
